/* shared/spc_pkg.sv */
// constants, register map and state type for the startup parameter check
// assumes a 20 MHz mclk and a 32-bit single-word register bus
package spc_pkg;

    // ==========================================================
    // clock and time
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // ==========================================================
    // widths
    localparam int unsigned CH_W = 8;
    localparam int unsigned FPAR_BYTES = 14;
    localparam logic [3:0] FPAR_LAST_IDX = 4'hd;

    // ==========================================================
    // address range of source and destination fields
    localparam logic [15:0] ADDR_MIN = 16'h0001;
    localparam logic [15:0] ADDR_MAX = 16'hfffe;

    // ==========================================================
    // safety parameter block layout, lsb positions in the 112-bit shift
    // register, first byte received lands in the top byte
    localparam int unsigned FP_SRC_LSB = 96;
    localparam int unsigned FP_DST_LSB = 80;
    localparam int unsigned FP_WD_LSB = 64;
    localparam int unsigned FP_FLG1_LSB = 56;
    localparam int unsigned FP_FLG2_LSB = 48;
    localparam int unsigned FP_ICRC_LSB = 16;
    localparam int unsigned FP_FCRC_LSB = 0;

    // ==========================================================
    // crc
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LADDR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] REG_CALC_CRC = 8'h14;
    localparam logic [7:0] REG_EXP_CRC = 8'h18;
    localparam logic [7:0] REG_WD_TIME = 8'h1c;
    localparam logic [7:0] REG_SRC_ADDR = 8'h20;
    localparam logic [7:0] REG_FLAGS = 8'h24;

    // control bits (write-one pulses)
    localparam int unsigned CTRL_LOAD_BIT = 0;
    localparam int unsigned CTRL_RESTART_BIT = 1;
    localparam int unsigned CTRL_REINIT_BIT = 2;

    // interrupt status bits
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned EV_RUN = 0;
    localparam int unsigned EV_CFG_ERR = 1;
    localparam int unsigned EV_ADDR_ERR = 2;
    localparam int unsigned EV_WD_EXP = 3;

    // ==========================================================
    // reset values
    localparam logic [15:0] LADDR_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [7:0] FW_REV_DEF = 8'h01;  // arbitrary value

    typedef enum logic [2:0] {
        SPC_INIT,
        SPC_IPAR,
        SPC_FWREV,
        SPC_FPAR,
        SPC_CHECK,
        SPC_RUN,
        SPC_FAILSAFE,
        SPC_CFG_ERR
    } spc_state_t;

endpackage

/* design/spc_crc32.sv */
// byte-serial 32-bit crc engine, one byte per clock
// assumes the caller clears it before a new data set
`timescale 1ns/1ps

module spc_crc32 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] din,
    output logic [31:0] crc_q
);

    // ==========================================================
    // one byte step of the reflected polynomial
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ spc_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // clear has priority so a new set never inherits a stale value
    always_ff @(posedge mclk) begin
        if (rst || clr) begin
            crc_q <= spc_pkg::CRC_INIT;
        end else if (en) begin
            crc_q <= crc_step(crc_q, din);
        end
    end

endmodule

/* design/spc_check.sv */
// startup parameter check of a safety slave with connection watchdog
// assumes ahb-lite single word transfers, one slave, bytes of the
// inter-controller channel are synchronous to mclk
`timescale 1ns/1ps

module spc_check #(
    parameter int unsigned MS_CYCLES = spc_pkg::MS_CYCLES,
    parameter logic [7:0] FW_REV = spc_pkg::FW_REV_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic icc_valid,
    input wire logic icc_kind,
    input wire logic [7:0] icc_byte,
    input wire logic icc_last,
    output logic icc_ready,
    input wire logic cyc_valid,
    input wire logic cyc_ok,
    input wire logic [spc_pkg::CH_W-1:0] di_field,
    input wire logic [spc_pkg::CH_W-1:0] do_host,
    output logic [spc_pkg::CH_W-1:0] di_safe_q,
    output logic [spc_pkg::CH_W-1:0] do_safe_q,
    output logic run_q,
    output logic cfg_err_msg_q,
    output logic irq
);

    spc_pkg::spc_state_t state_q, state_d;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [15:0] laddr_q;
    logic [15:0] loc_addr_q;
    logic [spc_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, ev_set;
    logic [111:0] fpar_q;
    logic [3:0] fidx_q;
    logic [15:0] ms_cnt_q, wd_cnt_q;
    logic [31:0] crc_raw, crc_final;
    logic ap, rd_clr, ld_p, rs_p, ri_p, icc_take, ipar_byte, fpar_byte;
    logic ms_tick, cyc_good, wd_exp, addr_ok, src_ok, crc_ok, check_ok;
    logic [15:0] f_src, f_dst, f_wd;

    // ==========================================================
    // bus slave: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign ap = hsel && hready && htrans[1];
    assign rd_clr = ap && !hwrite && (haddr == {24'h000000, spc_pkg::REG_IRQ_STAT});
    assign ld_p = wr_pend_q && (wr_addr_q == spc_pkg::REG_CTRL) && hwdata[spc_pkg::CTRL_LOAD_BIT];
    assign rs_p = wr_pend_q && (wr_addr_q == spc_pkg::REG_CTRL)
        && hwdata[spc_pkg::CTRL_RESTART_BIT];
    assign ri_p = wr_pend_q && (wr_addr_q == spc_pkg::REG_CTRL)
        && hwdata[spc_pkg::CTRL_REINIT_BIT];

    // address phase captured; upper address bits beyond the map are decoded
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= ap && hwrite && (haddr[31:8] == 24'h000000);
            wr_addr_q <= haddr[7:0];
        end
    end

    // read data is built in the address phase so it stands in the data phase
    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata_q <= 32'h00000000;
        end else if (ap && !hwrite) begin
            if (haddr[31:8] != 24'h000000) begin
                hrdata_q <= 32'h00000000;
            end else begin
                case (haddr[7:0])
                    spc_pkg::REG_LADDR: hrdata_q <= {16'h0000, laddr_q};
                    spc_pkg::REG_STATUS: hrdata_q <= {24'h000000, 4'h0, 1'b0, state_q};
                    spc_pkg::REG_IRQ_STAT: hrdata_q <= {28'h0000000, irq_stat_q};
                    spc_pkg::REG_IRQ_MASK: hrdata_q <= {28'h0000000, irq_mask_q};
                    spc_pkg::REG_CALC_CRC: hrdata_q <= crc_final;
                    spc_pkg::REG_EXP_CRC: hrdata_q <= fpar_q[spc_pkg::FP_ICRC_LSB +: 32];
                    spc_pkg::REG_WD_TIME: hrdata_q <= {16'h0000, f_wd};
                    spc_pkg::REG_SRC_ADDR: hrdata_q <= {16'h0000, f_src};
                    spc_pkg::REG_FLAGS: hrdata_q <= {fpar_q[spc_pkg::FP_FCRC_LSB +: 16],
                        fpar_q[spc_pkg::FP_FLG2_LSB +: 8], fpar_q[spc_pkg::FP_FLG1_LSB +: 8]};
                    default: hrdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // software registers: local address and interrupt mask
    always_ff @(posedge mclk) begin
        if (rst) begin
            laddr_q <= spc_pkg::LADDR_RST;
            irq_mask_q <= spc_pkg::IRQ_MASK_RST;
        end else if (wr_pend_q) begin
            if (wr_addr_q == spc_pkg::REG_LADDR) begin
                laddr_q <= hwdata[15:0];
            end
            if (wr_addr_q == spc_pkg::REG_IRQ_MASK) begin
                irq_mask_q <= hwdata[spc_pkg::IRQ_W-1:0];
            end
        end
    end

    // ==========================================================
    // interrupts: sticky, read clears, a new event beats the clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (rd_clr ? '0 : irq_stat_q) | ev_set;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // ==========================================================
    // inter-controller channel intake
    assign icc_ready = (state_q == spc_pkg::SPC_IPAR) || (state_q == spc_pkg::SPC_FPAR);
    assign icc_take = icc_valid && icc_ready;
    assign ipar_byte = icc_take && !icc_kind && (state_q == spc_pkg::SPC_IPAR);
    assign fpar_byte = icc_take && icc_kind && (state_q == spc_pkg::SPC_FPAR);

    // crc restarts on each load; revision byte is appended after the set
    spc_crc32 u_crc (
        .mclk(mclk),
        .rst(rst),
        .clr(ld_p || ri_p),
        .en(ipar_byte || (state_q == spc_pkg::SPC_FWREV)),
        .din((state_q == spc_pkg::SPC_FWREV) ? FW_REV : icc_byte),
        .crc_q(crc_raw)
    );
    assign crc_final = ~crc_raw;

    // safety block bytes shift in, first byte ends up on top
    always_ff @(posedge mclk) begin
        if (rst) begin
            fpar_q <= '0;
            fidx_q <= 4'h0;
        end else if (ld_p || ri_p) begin
            fidx_q <= 4'h0;
        end else if (fpar_byte) begin
            fpar_q <= {fpar_q[103:0], icc_byte};
            fidx_q <= fidx_q + 4'h1;
        end
    end

    // local address is copied into protocol logic at load time only
    always_ff @(posedge mclk) begin
        if (rst) begin
            loc_addr_q <= 16'h0000;
        end else if (ld_p && (state_q == spc_pkg::SPC_INIT)) begin
            loc_addr_q <= laddr_q;
        end
    end

    // ==========================================================
    // checks made on the complete block
    assign f_src = fpar_q[spc_pkg::FP_SRC_LSB +: 16];
    assign f_dst = fpar_q[spc_pkg::FP_DST_LSB +: 16];
    assign f_wd = fpar_q[spc_pkg::FP_WD_LSB +: 16];
    assign src_ok = (f_src >= spc_pkg::ADDR_MIN) && (f_src <= spc_pkg::ADDR_MAX);
    assign addr_ok = (f_dst >= spc_pkg::ADDR_MIN) && (f_dst <= spc_pkg::ADDR_MAX)
        && (f_dst == loc_addr_q);
    assign crc_ok = fpar_q[spc_pkg::FP_ICRC_LSB +: 32] == crc_final;
    assign check_ok = src_ok && addr_ok && crc_ok;

    // ==========================================================
    // connection watchdog, counted in milliseconds while running
    assign cyc_good = cyc_valid && cyc_ok;
    assign ms_tick = ms_cnt_q == 16'(MS_CYCLES - 1);
    assign wd_exp = (state_q == spc_pkg::SPC_RUN) && ms_tick && (wd_cnt_q == 16'h0000)
        && !cyc_good;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ms_cnt_q <= 16'h0000;
            wd_cnt_q <= 16'h0000;
        end else if ((state_q != spc_pkg::SPC_RUN) || cyc_good) begin
            ms_cnt_q <= 16'h0000;
            wd_cnt_q <= f_wd;
        end else if (ms_tick) begin
            ms_cnt_q <= 16'h0000;
            wd_cnt_q <= wd_cnt_q - 16'h0001;
        end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // startup sequence; reinit from any state returns to init
    always_comb begin
        state_d = state_q;
        ev_set = '0;
        if (ri_p) begin
            state_d = spc_pkg::SPC_INIT;
        end else begin
            case (state_q)
                spc_pkg::SPC_INIT: begin
                    if (ld_p) begin
                        state_d = spc_pkg::SPC_IPAR;
                    end
                end
                spc_pkg::SPC_IPAR: begin
                    if (ipar_byte && icc_last) begin
                        state_d = spc_pkg::SPC_FWREV;
                    end
                end
                spc_pkg::SPC_FWREV: state_d = spc_pkg::SPC_FPAR;
                spc_pkg::SPC_FPAR: begin
                    if (fpar_byte && (fidx_q == spc_pkg::FPAR_LAST_IDX)) begin
                        state_d = spc_pkg::SPC_CHECK;
                    end
                end
                spc_pkg::SPC_CHECK: begin
                    if (check_ok) begin
                        state_d = spc_pkg::SPC_RUN;
                        ev_set[spc_pkg::EV_RUN] = 1'b1;
                    end else begin
                        state_d = spc_pkg::SPC_CFG_ERR;
                        ev_set[spc_pkg::EV_CFG_ERR] = !crc_ok;
                        ev_set[spc_pkg::EV_ADDR_ERR] = !(addr_ok && src_ok);
                    end
                end
                spc_pkg::SPC_RUN: begin
                    if (wd_exp) begin
                        state_d = spc_pkg::SPC_FAILSAFE;
                        ev_set[spc_pkg::EV_WD_EXP] = 1'b1;
                    end
                end
                spc_pkg::SPC_FAILSAFE: begin
                    if (rs_p) begin
                        state_d = spc_pkg::SPC_RUN;
                    end
                end
                spc_pkg::SPC_CFG_ERR: state_d = spc_pkg::SPC_CFG_ERR;
                default: state_d = spc_pkg::SPC_INIT;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= spc_pkg::SPC_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // cyclic data passes only in run, otherwise fail-safe zeros
    always_ff @(posedge mclk) begin
        if (rst) begin
            di_safe_q <= '0;
            do_safe_q <= '0;
            run_q <= 1'b0;
            cfg_err_msg_q <= 1'b0;
        end else begin
            di_safe_q <= (state_q == spc_pkg::SPC_RUN) ? di_field : '0;
            do_safe_q <= (state_q == spc_pkg::SPC_RUN) ? do_host : '0;
            run_q <= state_d == spc_pkg::SPC_RUN;
            cfg_err_msg_q <= (state_q == spc_pkg::SPC_CHECK) && !crc_ok && !ri_p;
        end
    end

    // ==========================================================
    // checks
    property p_addr_load;
        @(posedge mclk) disable iff (rst)
        (ld_p && state_q == spc_pkg::SPC_INIT) |=> (loc_addr_q == $past(laddr_q));
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("local address not loaded");

    property p_fw_fold;
        @(posedge mclk) disable iff (rst)
        (ipar_byte && icc_last && !ri_p) |=> (state_q == spc_pkg::SPC_FWREV)
            ##1 (state_q == spc_pkg::SPC_FPAR || $past(ri_p));
    endproperty
    a_fw_fold: assert property (p_fw_fold) else $error("revision byte not folded");

    property p_no_run_on_mismatch;
        @(posedge mclk) disable iff (rst)
        (state_q == spc_pkg::SPC_CHECK && !crc_ok && !ri_p) |=> !run_q
            && (state_q == spc_pkg::SPC_CFG_ERR);
    endproperty
    a_no_run_on_mismatch: assert property (p_no_run_on_mismatch) else $error("ran on crc mismatch");

    property p_addr_block;
        @(posedge mclk) disable iff (rst)
        (state_q == spc_pkg::SPC_CHECK && f_dst != loc_addr_q) |=> state_q != spc_pkg::SPC_RUN;
    endproperty
    a_addr_block: assert property (p_addr_block) else $error("ran with wrong address");

    property p_run_load;
        @(posedge mclk) disable iff (rst)
        (state_q == spc_pkg::SPC_CHECK && check_ok && !ri_p) |=> run_q && (wd_cnt_q == f_wd);
    endproperty
    a_run_load: assert property (p_run_load) else $error("run entry without watchdog load");

    property p_reload;
        @(posedge mclk) disable iff (rst)
        (state_q == spc_pkg::SPC_RUN && cyc_good) |=> (wd_cnt_q == f_wd) && (ms_cnt_q == 16'h0000);
    endproperty
    a_reload: assert property (p_reload) else $error("watchdog not reloaded");

    property p_expire;
        @(posedge mclk) disable iff (rst)
        (wd_exp && !ri_p) |=> (state_q == spc_pkg::SPC_FAILSAFE) ##1 (do_safe_q == '0)
            && (di_safe_q == '0) && irq_stat_q[spc_pkg::EV_WD_EXP];
    endproperty
    a_expire: assert property (p_expire) else $error("expiry not fail-safe");

    property p_cfg_msg;
        @(posedge mclk) disable iff (rst)
        $rose(cfg_err_msg_q) |-> ($past(state_q) == spc_pkg::SPC_CHECK) && (do_safe_q == '0)
            ##1 !cfg_err_msg_q;
    endproperty
    a_cfg_msg: assert property (p_cfg_msg) else $error("config error message wrong");

endmodule

/* sim/spc_ctrl_model.sv */
// far-side model of the communication controller that feeds the channel
// assumes icc_ready of the check block is settled by the falling edge
`timescale 1ns/1ps

module spc_ctrl_model (
    input wire logic mclk,
    input wire logic icc_ready,
    output logic icc_valid,
    output logic icc_kind,
    output logic [7:0] icc_byte,
    output logic icc_last
);
    // ==========================================================
    // channel driver
    initial begin
        icc_valid = 1'b0;
        icc_kind = 1'b0;
        icc_byte = 8'h00;
        icc_last = 1'b0;
    end

    // released lines show the inverted last byte, so a stale copy is never mistaken
    task automatic idle();
        icc_valid <= 1'b0;
        icc_last <= 1'b0;
        icc_byte <= ~icc_byte;
    endtask

    // one byte held until taken; gap idles first to play a slow host
    task automatic put(input logic k, input logic [7:0] b, input logic l, input int gap,
                       output logic ok);
        ok = 1'b0;
        if (gap > 0) begin
            idle();
            repeat (gap) @(posedge mclk);
        end
        icc_valid <= 1'b1;
        icc_kind <= k;
        icc_byte <= b;
        icc_last <= l;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(negedge mclk);
            ok = (icc_ready === 1'b1);
            @(posedge mclk);
        end
    endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the startup parameter check
// assumes spc_pkg and the controller model are compiled before it
`timescale 1ns/1ps

module tb_top;
    localparam int unsigned MSC = 10;
    localparam logic [7:0] FWR = 8'h5a;  // arbitrary revision value
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, icc_valid, icc_kind, icc_last, icc_ready, run_q, cfg_err_msg_q, irq;
    logic [7:0] icc_byte, di_safe_q, do_safe_q;
    logic cyc_valid = 1'b0;
    logic cyc_ok = 1'b0;
    logic [7:0] di_field = 8'h0;
    logic [7:0] do_host = 8'h0;
    int err_total = 0;
    int checks_done = 0;
    int cfg_pulses = 0;
    logic [3:0] irq_exp = 4'h0;  // model of the sticky status bits
    logic [3:0] mask = 4'hb;  // bit2 kept masked to see masking work
    logic [31:0] rd;
    logic [7:0] app_q[$];

    always #25 mclk = ~mclk;

    // the error message pulse lasts one cycle, so counting edges counts pulses
    always @(posedge mclk) if (cfg_err_msg_q === 1'b1) cfg_pulses++;

    spc_check #(.MS_CYCLES(MSC), .FW_REV(FWR)) i_spc_check (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .icc_valid(icc_valid),
        .icc_kind(icc_kind), .icc_byte(icc_byte), .icc_last(icc_last),
        .icc_ready(icc_ready), .cyc_valid(cyc_valid), .cyc_ok(cyc_ok),
        .di_field(di_field), .do_host(do_host), .di_safe_q(di_safe_q),
        .do_safe_q(do_safe_q), .run_q(run_q), .cfg_err_msg_q(cfg_err_msg_q), .irq(irq)
    );

    spc_ctrl_model u_ctrl (
        .mclk(mclk), .icc_ready(icc_ready), .icc_valid(icc_valid), .icc_kind(icc_kind),
        .icc_byte(icc_byte), .icc_last(icc_last)
    );

    // ==========================================================
    // reporting
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        print_verdict();
    end

    // ==========================================================
    // bus master: hreadyout is settled by the falling edge, data taken at that same falling edge
    task automatic bus_wait(output logic [31:0] d);
        logic done;
        done = 1'b0;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge mclk);
            d = hrdata;
            done = (hreadyout === 1'b1);
            @(posedge mclk);
        end
        if (!done) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        bus_wait(d);
        htrans <= 2'h0;
        hwdata <= wd;
        bus_wait(d);
    endtask

    // irq level first, then the read that clears the sticky bits
    task automatic irq_chk();
        @(negedge mclk);
        chk("irq", irq, {31'h0, |(irq_exp & mask)});
        @(posedge mclk);
        bus(1'b0, spc_pkg::REG_IRQ_STAT, 32'h0, rd);
        chk("irq_stat", rd, {28'h0, irq_exp});
        irq_exp = 4'h0;
    endtask

    // safe data pass one cycle late in run, else forced to zero
    task automatic io_chk(input logic on);
        di_field <= 8'($urandom);
        do_host <= 8'($urandom);
        @(posedge mclk);
        @(negedge mclk);
        chk("di_safe", di_safe_q, on ? di_field : 8'h0);
        chk("do_safe", do_safe_q, on ? do_host : 8'h0);
        @(posedge mclk);
    endtask

    // ==========================================================
    // reference crc: reflected, bytes in order then the revision byte
    function automatic logic [31:0] crc_of(input logic [7:0] fw);
        logic [31:0] c;
        logic [7:0] b;
        c = spc_pkg::CRC_INIT;
        for (int i = 0; i <= app_q.size(); i++) begin
            b = (i < app_q.size()) ? app_q[i] : fw;
            for (int k = 0; k < 8; k++) begin
                c = (c[0] ^ b[k]) ? ((c >> 1) ^ spc_pkg::CRC_POLY) : (c >> 1);
            end
        end
        return ~c;
    endfunction

    // mode 0 good, 1 crc off by one bit, 2 wrong destination, 3 source zero
    task automatic startup(input int mode, input logic [15:0] la, input logic [15:0] wd);
        logic [111:0] blk;
        logic [31:0] crc;
        logic [15:0] src;
        logic [2:0] st;
        logic ok;
        int p0;
        app_q.delete();
        repeat ($urandom_range(8, 1)) app_q.push_back(8'($urandom));
        crc = crc_of(FWR);
        src = (mode == 3) ? 16'h0 : 16'($urandom_range(65534, 1));
        blk = {src, (mode == 2) ? la + 16'h1 : la, wd, 8'h3c, 8'hc3,
               (mode == 1) ? crc ^ 32'h1 : crc, 16'ha55a};
        st = (mode == 0) ? 3'h5 : 3'h7;
        p0 = cfg_pulses;
        bus(1'b1, spc_pkg::REG_CTRL, 32'h4, rd);
        bus(1'b1, spc_pkg::REG_LADDR, {16'h0, la}, rd);
        bus(1'b1, spc_pkg::REG_CTRL, 32'h1, rd);
        foreach (app_q[i]) begin
            u_ctrl.put(1'b0, app_q[i], i == app_q.size() - 1, i % 2, ok);
            chk("app byte taken", ok, 1);
        end
        for (int i = 13; i >= 0; i--) begin
            u_ctrl.put(1'b1, blk[i*8 +: 8], 1'b0, (i % 5 == 0) ? 2 : 0, ok);
            chk("block byte taken", ok, 1);
        end
        u_ctrl.idle();
        rd = 32'h3;
        for (int n = 0; n < 8 && (rd == 32'h3 || rd == 32'h4); n++) begin
            bus(1'b0, spc_pkg::REG_STATUS, 32'h0, rd);
        end
        chk("status", rd, {29'h0, st});
        chk("run", run_q, {31'h0, mode == 0});
        chk("error pulses", cfg_pulses - p0, (mode == 1) ? 1 : 0);
        bus(1'b0, spc_pkg::REG_CALC_CRC, 32'h0, rd);
        chk("calc crc", rd, crc);
        bus(1'b0, spc_pkg::REG_EXP_CRC, 32'h0, rd);
        chk("exp crc", rd, blk[47:16]);
        bus(1'b0, spc_pkg::REG_WD_TIME, 32'h0, rd);
        chk("wd time", rd, {16'h0, wd});
        bus(1'b0, spc_pkg::REG_SRC_ADDR, 32'h0, rd);
        chk("src addr", rd, {16'h0, src});
        bus(1'b0, spc_pkg::REG_FLAGS, 32'h0, rd);
        chk("flags", rd, 32'ha55ac33c);
        irq_exp = (mode == 0) ? 4'h1 : (mode == 1) ? 4'h2 : 4'h4;
        irq_chk();
        io_chk(mode == 0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int cnt;
        void'($urandom(32'he67a));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk("ready in init", icc_ready, 0);
        chk("hresp", hresp, 0);
        @(posedge mclk);
        bus(1'b0, spc_pkg::REG_STATUS, 32'h0, rd);
        chk("status rst", rd, 0);
        bus(1'b0, spc_pkg::REG_IRQ_MASK, 32'h0, rd);
        chk("mask rst", rd, 0);
        bus(1'b0, spc_pkg::REG_LADDR, 32'h0, rd);
        chk("laddr rst", rd, 0);
        bus(1'b1, 8'h40, 32'hffffffff, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped", rd, 0);
        bus(1'b1, spc_pkg::REG_IRQ_MASK, {28'h0, mask}, rd);
        for (int m = 1; m <= 3; m++) startup(m, 16'($urandom_range(65533, 1)), 16'h2);
        startup(0, 16'($urandom_range(65534, 1)), 16'h2);
        // messages inside the window keep the link alive; first one right after the startup checks
        cyc_valid <= 1'b1;
        cyc_ok <= 1'b1;
        @(posedge mclk);
        cyc_valid <= 1'b0;
        repeat (5) begin
            repeat (20) @(posedge mclk);
            cyc_valid <= 1'b1;
            cyc_ok <= 1'b1;
            @(posedge mclk);
            cyc_valid <= 1'b0;
        end
        @(negedge mclk);
        chk("run kept", run_q, 1);
        // a message with bad content midway must not reload the count
        cnt = 0;
        while (cnt < 200 && run_q === 1'b1) begin
            @(posedge mclk);
            cnt++;
            cyc_valid <= (cnt == 10);
            cyc_ok <= 1'b0;
            @(negedge mclk);
        end
        chk("expiry near 3 ms", cnt >= 3 * MSC - 1 && cnt <= 3 * MSC + 1, 1);
        @(posedge mclk);
        io_chk(1'b0);
        cyc_valid <= 1'b1;
        cyc_ok <= 1'b1;
        @(posedge mclk);
        cyc_valid <= 1'b0;
        bus(1'b0, spc_pkg::REG_STATUS, 32'h0, rd);
        chk("waits restart", rd, 32'h6);
        irq_exp = 4'h8;
        irq_chk();
        bus(1'b1, spc_pkg::REG_CTRL, 32'h2, rd);
        bus(1'b0, spc_pkg::REG_STATUS, 32'h0, rd);
        chk("restarted", rd, 32'h5);
        io_chk(1'b1);
        print_verdict();
    end
endmodule
